/* hw/pdcs_pkg.sv */
// Purpose: Constants shared by the panel display command state block
// Assumes: Byte-wide host writes addressed by command offset
// Notes:   Offsets are the command and parameter addresses
package pdcs_pkg;
	localparam int          ADDR_W = 16;
	localparam int          POS_W  = 10;
	localparam int          PIX_W  = 24;

	localparam logic [15:0] FORCE_ALL_BLACK_CMD   = 16'h2200;
	localparam logic [15:0] FORCE_ALL_WHITE_CMD   = 16'h2300;
	localparam logic [15:0] IMAGE_OUTPUT_STOP_CMD = 16'h2800;
	localparam logic [15:0] IMAGE_OUTPUT_START_CMD = 16'h2900;
	localparam logic [15:0] FRAME_WRITE_BEGIN_CMD  = 16'h2c00;
	localparam logic [15:0] FRAME_WRITE_RESUME_CMD = 16'h3c00;
	localparam logic [15:0] TEAR_LINE_DISABLE_CMD  = 16'h3400;
	localparam logic [15:0] PARTIAL_MODE_ON_CMD    = 16'h1200;
	localparam logic [15:0] NORMAL_MODE_ON_CMD     = 16'h1300;

	localparam logic [15:0] COLUMN_START_HIGH      = 16'h2a00;
	localparam logic [15:0] COLUMN_START_LOW       = 16'h2a01;
	localparam logic [15:0] COLUMN_END_HIGH        = 16'h2a02;
	localparam logic [15:0] COLUMN_END_LOW         = 16'h2a03;
	localparam logic [15:0] ROW_START_HIGH         = 16'h2b00;
	localparam logic [15:0] ROW_START_LOW          = 16'h2b01;
	localparam logic [15:0] ROW_END_HIGH           = 16'h2b02;
	localparam logic [15:0] ROW_END_LOW            = 16'h2b03;
	localparam logic [15:0] PARTIAL_START_ROW_HIGH = 16'h3000;
	localparam logic [15:0] PARTIAL_START_ROW_LOW  = 16'h3001;
	localparam logic [15:0] PARTIAL_END_ROW_HIGH   = 16'h3002;
	localparam logic [15:0] PARTIAL_END_ROW_LOW    = 16'h3003;
	localparam logic [15:0] VERTICAL_PARTIAL_START_HIGH = 16'h3100;
	localparam logic [15:0] VERTICAL_PARTIAL_START_LOW  = 16'h3101;
	localparam logic [15:0] VERTICAL_PARTIAL_END_HIGH   = 16'h3102;
	localparam logic [15:0] VERTICAL_PARTIAL_END_LOW    = 16'h3103;
	localparam logic [15:0] TEAR_OUTPUT_CONTROL    = 16'h3500;
	localparam logic [15:0] SCAN_DIRECTION_CONTROL = 16'h3600;

	localparam logic [7:0]  START_HIGH_RESET = 8'h00;
	localparam logic [7:0]  START_LOW_RESET  = 8'h00;
	localparam logic [7:0]  END_HIGH_RESET   = 8'h01;
	localparam logic [7:0]  END_LOW_RESET    = 8'hdf;
	localparam logic [7:0]  TEAR_CTRL_RESET  = 8'h00;
	localparam logic [7:0]  SCAN_CTRL_RESET  = 8'h00;

	localparam int          TEAR_BLANKING_BIT = 0;
	localparam int          TEAR_REFRESH_BIT  = 1;
	localparam int          COLUMN_REVERSE_BIT = 6;
	localparam int          BGR_ORDER_BIT      = 3;

	localparam logic [23:0] PIXEL_BLACK = 24'h000000;
	localparam logic [23:0] PIXEL_WHITE = 24'hffffff;

	typedef enum logic [0:0] {
		PDCS_IDLE    = 1'b0,
		PDCS_WRITING = 1'b1
	} pdcs_write_state_type;
endpackage

/* hw/pdcs_window_stepper.sv */
// Purpose: Frame memory write position inside the column and row window
// Assumes: Window latched on load, one step per pixel written
// Notes:   Reverse columns run from last column down to first
`timescale 1ns/10ps
module pdcs_window_stepper import pdcs_pkg::*; (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              load,
	input  wire logic              step,
	input  wire logic [POS_W-1:0]  firstColumn,
	input  wire logic [POS_W-1:0]  lastColumn,
	input  wire logic [POS_W-1:0]  firstRow,
	input  wire logic [POS_W-1:0]  lastRow,
	input  wire logic              reverse,
	output logic      [POS_W-1:0]  column,
	output logic      [POS_W-1:0]  row
);
	logic [POS_W-1:0] firstColumn_reg;
	logic [POS_W-1:0] lastColumn_reg;
	logic [POS_W-1:0] firstRow_reg;
	logic [POS_W-1:0] lastRow_reg;
	logic             reverse_reg;
	logic             lineEnd;

	assign lineEnd = reverse_reg ? (column == firstColumn_reg) : (column == lastColumn_reg);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			firstColumn_reg <= '0;
			lastColumn_reg  <= '0;
			firstRow_reg    <= '0;
			lastRow_reg     <= '0;
			reverse_reg     <= 1'b0;
		end else if (load) begin
			firstColumn_reg <= firstColumn;
			lastColumn_reg  <= lastColumn;
			firstRow_reg    <= firstRow;
			lastRow_reg     <= lastRow;
			reverse_reg     <= reverse;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			column <= '0;
			row    <= '0;
		end else if (load) begin
			column <= reverse ? lastColumn : firstColumn;
			row    <= firstRow;
		end else if (step) begin
			if (lineEnd) begin
				column <= reverse_reg ? lastColumn_reg : firstColumn_reg;
				row    <= (row == lastRow_reg) ? firstRow_reg : row + 10'h001;
			end else begin
				column <= reverse_reg ? column - 10'h001 : column + 10'h001;
			end
		end
	end

	a_begin_position: assert property (@(posedge ref_clk) disable iff (rst)
		load && !reverse |=> column == $past(firstColumn) && row == $past(firstRow))
		else $error("write did not start at window");
	// Checked against the latched bounds, so window bytes sent mid-stream are harmless
	a_column_advance: assert property (@(posedge ref_clk) disable iff (rst)
		step && !load && !reverse_reg && column != lastColumn_reg
		|=> column == $past(column) + 10'h001)
		else $error("column did not advance");
endmodule // pdcs_window_stepper

/* hw/pdcs_command_state.sv */
// Purpose: Command state of the panel driver: forced fill, image output,
//          write window, partial area, tearing line and scan direction
// Assumes: Timing inputs and sleep come from logic on ref_clk
// Notes:   Each command or parameter byte is one hostWrite cycle
`timescale 1ns/10ps
module pdcs_command_state import pdcs_pkg::*; (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              hostWrite,
	input  wire logic [ADDR_W-1:0] hostAddr,
	input  wire logic [7:0]        hostData,
	input  wire logic              pixelValid,
	input  wire logic [PIX_W-1:0]  pixelData,
	input  wire logic              sleepMode,
	input  wire logic [PIX_W-1:0]  framePixel,
	input  wire logic [POS_W-1:0]  scanRow,
	input  wire logic              verticalBlank,
	input  wire logic              horizontalBlank,
	input  wire logic              refreshFrame,
	output logic                   pixelReady,
	output logic                   frameWrite,
	output logic      [POS_W-1:0]  frameColumn,
	output logic      [POS_W-1:0]  frameRow,
	output logic      [PIX_W-1:0]  frameData,
	output logic      [PIX_W-1:0]  panelPixel,
	output logic                   panelEnable,
	output logic                   rowShown,
	output logic                   tearSyncOutput,
	output logic                   imageOutputOn,
	output logic                   forceBlack,
	output logic                   forceWhite,
	output logic                   partialMode,
	output logic                   tearEnable,
	output logic                   tearBlankingSelect,
	output logic                   tearRefreshSelect,
	output logic                   columnReverse,
	output logic                   bgrOrder,
	output logic      [POS_W-1:0]  partialFirstRow,
	output logic      [POS_W-1:0]  partialLastRow,
	output logic      [8:0]        verticalFirstColumn,
	output logic      [8:0]        verticalLastColumn
);
	function automatic logic [POS_W-1:0] join10(input logic [7:0] hi, input logic [7:0] lo);
		return {hi[1:0], lo};
	endfunction
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
		return a == b;
	endfunction
	logic [7:0] colStartHigh_reg;
	logic [7:0] colStartLow_reg;
	logic [7:0] colEndHigh_reg;
	logic [7:0] colEndLow_reg;
	logic [7:0] rowStartHigh_reg;
	logic [7:0] rowStartLow_reg;
	logic [7:0] rowEndHigh_reg;
	logic [7:0] rowEndLow_reg;
	logic [7:0] ptlStartHigh_reg;
	logic [7:0] ptlStartLow_reg;
	logic [7:0] ptlEndHigh_reg;
	logic [7:0] ptlEndLow_reg;
	logic [7:0] vptStartHigh_reg;
	logic [7:0] vptStartLow_reg;
	logic [7:0] vptEndHigh_reg;
	logic [7:0] vptEndLow_reg;
	logic [7:0] tearCtrl_reg;
	logic [7:0] scanCtrl_reg;
	logic       tearEnable_reg;
	logic       imageOn_reg;
	logic       forceBlack_reg;
	logic       forceWhite_reg;
	logic       partial_reg;
	pdcs_write_state_type writeState_reg;
	pdcs_write_state_type writeState_next;
	logic [POS_W-1:0] windowFirstColumn;
	logic [POS_W-1:0] windowLastColumn;
	logic [POS_W-1:0] windowFirstRow;
	logic [POS_W-1:0] windowLastRow;
	logic [POS_W-1:0] curColumn;
	logic [POS_W-1:0] curRow;
	logic             beginHit;
	logic             resumeHit;
	logic             pixelTake;
	logic [PIX_W-1:0] imagePixel;
	assign windowFirstColumn = join10(colStartHigh_reg, colStartLow_reg);
	assign windowLastColumn  = join10(colEndHigh_reg, colEndLow_reg);
	assign windowFirstRow    = join10(rowStartHigh_reg, rowStartLow_reg);
	assign windowLastRow     = join10(rowEndHigh_reg, rowEndLow_reg);
	assign partialFirstRow   = join10(ptlStartHigh_reg, ptlStartLow_reg);
	assign partialLastRow    = join10(ptlEndHigh_reg, ptlEndLow_reg);
	assign verticalFirstColumn = {vptStartHigh_reg[0], vptStartLow_reg};
	assign verticalLastColumn  = {vptEndHigh_reg[0], vptEndLow_reg};
	assign beginHit  = hostWrite && hit(hostAddr, FRAME_WRITE_BEGIN_CMD);
	assign resumeHit = hostWrite && hit(hostAddr, FRAME_WRITE_RESUME_CMD);
	assign pixelReady = (writeState_reg == PDCS_WRITING) && !hostWrite;
	assign pixelTake  = pixelValid && pixelReady;
	assign imageOutputOn      = imageOn_reg;
	assign forceBlack         = forceBlack_reg;
	assign forceWhite         = forceWhite_reg;
	assign partialMode        = partial_reg;
	assign tearEnable         = tearEnable_reg;
	assign tearBlankingSelect = tearCtrl_reg[TEAR_BLANKING_BIT];
	assign tearRefreshSelect  = tearCtrl_reg[TEAR_REFRESH_BIT];
	assign columnReverse      = scanCtrl_reg[COLUMN_REVERSE_BIT];
	assign bgrOrder           = scanCtrl_reg[BGR_ORDER_BIT];
	// Window bytes apply at once; the stepper copies them only on begin
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			colStartHigh_reg <= START_HIGH_RESET;
			colStartLow_reg  <= START_LOW_RESET;
			colEndHigh_reg   <= END_HIGH_RESET;
			colEndLow_reg    <= END_LOW_RESET;
			rowStartHigh_reg <= START_HIGH_RESET;
			rowStartLow_reg  <= START_LOW_RESET;
			rowEndHigh_reg   <= END_HIGH_RESET;
			rowEndLow_reg    <= END_LOW_RESET;
		end else if (hostWrite) begin
			unique case (hostAddr)
				COLUMN_START_HIGH: colStartHigh_reg <= hostData;
				COLUMN_START_LOW:  colStartLow_reg  <= hostData;
				COLUMN_END_HIGH:   colEndHigh_reg   <= hostData;
				COLUMN_END_LOW:    colEndLow_reg    <= hostData;
				ROW_START_HIGH:    rowStartHigh_reg <= hostData;
				ROW_START_LOW:     rowStartLow_reg  <= hostData;
				ROW_END_HIGH:      rowEndHigh_reg   <= hostData;
				ROW_END_LOW:       rowEndLow_reg    <= hostData;
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ptlStartHigh_reg <= START_HIGH_RESET;
			ptlStartLow_reg  <= START_LOW_RESET;
			ptlEndHigh_reg   <= END_HIGH_RESET;
			ptlEndLow_reg    <= END_LOW_RESET;
			vptStartHigh_reg <= START_HIGH_RESET;
			vptStartLow_reg  <= START_LOW_RESET;
			vptEndHigh_reg   <= END_HIGH_RESET;
			vptEndLow_reg    <= END_LOW_RESET;
		end else if (hostWrite) begin
			unique case (hostAddr)
				PARTIAL_START_ROW_HIGH:      ptlStartHigh_reg <= hostData;
				PARTIAL_START_ROW_LOW:       ptlStartLow_reg  <= hostData;
				PARTIAL_END_ROW_HIGH:        ptlEndHigh_reg   <= hostData;
				PARTIAL_END_ROW_LOW:         ptlEndLow_reg    <= hostData;
				VERTICAL_PARTIAL_START_HIGH: vptStartHigh_reg <= hostData;
				VERTICAL_PARTIAL_START_LOW:  vptStartLow_reg  <= hostData;
				VERTICAL_PARTIAL_END_HIGH:   vptEndHigh_reg   <= hostData;
				VERTICAL_PARTIAL_END_LOW:    vptEndLow_reg    <= hostData;
				default: ;
			endcase
		end
	end
	// Mode byte is kept while the line is on, so a repeat enable is a no-op
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tearEnable_reg <= 1'b0;
			tearCtrl_reg   <= TEAR_CTRL_RESET;
		end else if (hostWrite && hit(hostAddr, TEAR_LINE_DISABLE_CMD)) begin
			tearEnable_reg <= 1'b0;
		end else if (hostWrite && hit(hostAddr, TEAR_OUTPUT_CONTROL) && !tearEnable_reg) begin
			tearEnable_reg <= 1'b1;
			tearCtrl_reg   <= hostData;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scanCtrl_reg <= SCAN_CTRL_RESET;
		end else if (hostWrite && hit(hostAddr, SCAN_DIRECTION_CONTROL)) begin
			scanCtrl_reg <= hostData;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			imageOn_reg <= 1'b0;
		end else if (hostWrite && hit(hostAddr, IMAGE_OUTPUT_STOP_CMD)) begin
			imageOn_reg <= 1'b0;
		end else if (hostWrite && hit(hostAddr, IMAGE_OUTPUT_START_CMD)) begin
			imageOn_reg <= 1'b1;
		end
	end
	// Forced fill never touches image on/off or partial state
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			forceBlack_reg <= 1'b0;
			forceWhite_reg <= 1'b0;
			partial_reg    <= 1'b0;
		end else if (hostWrite) begin
			unique case (hostAddr)
				FORCE_ALL_BLACK_CMD: begin
					forceBlack_reg <= 1'b1;
					forceWhite_reg <= 1'b0;
				end
				FORCE_ALL_WHITE_CMD: begin
					forceWhite_reg <= 1'b1;
					forceBlack_reg <= 1'b0;
				end
				NORMAL_MODE_ON_CMD: begin
					forceBlack_reg <= 1'b0;
					forceWhite_reg <= 1'b0;
					partial_reg    <= 1'b0;
				end
				PARTIAL_MODE_ON_CMD: begin
					forceBlack_reg <= 1'b0;
					forceWhite_reg <= 1'b0;
					partial_reg    <= 1'b1;
				end
				default: ;
			endcase
		end
	end
	// Any other host byte closes the pixel stream
	always_comb begin
		writeState_next = writeState_reg;
		if (beginHit || resumeHit) begin
			writeState_next = PDCS_WRITING;
		end else if (hostWrite) begin
			writeState_next = PDCS_IDLE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			writeState_reg <= PDCS_IDLE;
		end else begin
			writeState_reg <= writeState_next;
		end
	end
	// Resume does not reload, so the position follows the last pixel
	pdcs_window_stepper stepper (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.load        (beginHit),
		.step        (pixelTake),
		.firstColumn (windowFirstColumn),
		.lastColumn  (windowLastColumn),
		.firstRow    (windowFirstRow),
		.lastRow     (windowLastRow),
		.reverse     (scanCtrl_reg[COLUMN_REVERSE_BIT]),
		.column      (curColumn),
		.row         (curRow)
	);
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			frameWrite  <= 1'b0;
			frameColumn <= '0;
			frameRow    <= '0;
			frameData   <= '0;
		end else begin
			frameWrite  <= pixelTake;
			frameColumn <= curColumn;
			frameRow    <= curRow;
			frameData   <= pixelData;
		end
	end
	assign imagePixel = bgrOrder ?
		{framePixel[7:0], framePixel[15:8], framePixel[23:16]} : framePixel;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			panelPixel  <= PIXEL_BLACK;
			panelEnable <= 1'b0;
		end else if (sleepMode) begin
			panelPixel  <= PIXEL_BLACK;
			panelEnable <= 1'b0;
		end else if (forceBlack_reg) begin
			panelPixel  <= PIXEL_BLACK;
			panelEnable <= 1'b1;
		end else if (forceWhite_reg) begin
			panelPixel  <= PIXEL_WHITE;
			panelEnable <= 1'b1;
		end else begin
			panelPixel  <= imageOn_reg ? imagePixel : PIXEL_BLACK;
			panelEnable <= imageOn_reg;
		end
	end
	// Equal rows give one row; reversed bounds wrap through row zero
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rowShown <= 1'b1;
		end else if (!partial_reg) begin
			rowShown <= 1'b1;
		end else if (partialLastRow >= partialFirstRow) begin
			rowShown <= (scanRow >= partialFirstRow) && (scanRow <= partialLastRow);
		end else begin
			rowShown <= (scanRow >= partialFirstRow) || (scanRow <= partialLastRow);
		end
	end
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tearSyncOutput <= 1'b0;
		end else if (sleepMode) begin
			tearSyncOutput <= 1'b0;
		end else begin
			tearSyncOutput <= tearEnable_reg
				&& (verticalBlank || (tearBlankingSelect && horizontalBlank))
				&& (!tearRefreshSelect || refreshFrame);
		end
	end
	a_black_fill: assert property (@(posedge ref_clk) disable iff (rst)
		forceBlack_reg && !sleepMode |=> panelPixel == PIXEL_BLACK && panelEnable)
		else $error("forced black not shown");
	a_white_fill: assert property (@(posedge ref_clk) disable iff (rst)
		forceWhite_reg && !sleepMode |=> panelPixel == PIXEL_WHITE && panelEnable)
		else $error("forced white not shown");
	a_force_exit: assert property (@(posedge ref_clk) disable iff (rst)
		hostWrite && (hostAddr == NORMAL_MODE_ON_CMD || hostAddr == PARTIAL_MODE_ON_CMD)
		|=> !forceBlack_reg && !forceWhite_reg)
		else $error("forced fill survived mode command");
	a_force_single: assert property (@(posedge ref_clk) disable iff (rst)
		!(forceBlack_reg && forceWhite_reg))
		else $error("black and white forced together");
	a_image_return: assert property (@(posedge ref_clk) disable iff (rst)
		hostWrite && hostAddr == NORMAL_MODE_ON_CMD && imageOn_reg && !sleepMode
		##1 !sleepMode && imageOn_reg |=> panelPixel == $past(imagePixel))
		else $error("image not restored");
	a_display_off: assert property (@(posedge ref_clk) disable iff (rst)
		hostWrite && hostAddr == IMAGE_OUTPUT_STOP_CMD |=> !imageOn_reg
		&& $stable(forceBlack_reg) && $stable(partial_reg))
		else $error("display off misbehaved");
	a_display_on: assert property (@(posedge ref_clk) disable iff (rst)
		hostWrite && hostAddr == IMAGE_OUTPUT_START_CMD |=> imageOn_reg
		&& $stable(forceWhite_reg) && $stable(tearEnable_reg))
		else $error("display on misbehaved");
	a_tear_repeat: assert property (@(posedge ref_clk) disable iff (rst)
		tearEnable_reg && hostWrite && hostAddr == TEAR_OUTPUT_CONTROL |=> $stable(tearCtrl_reg))
		else $error("repeat tear enable changed mode");
	a_tear_sleep: assert property (@(posedge ref_clk) disable iff (rst)
		sleepMode |=> !tearSyncOutput)
		else $error("tear line active in sleep");
	a_tear_off: assert property (@(posedge ref_clk) disable iff (rst)
		hostWrite && hostAddr == TEAR_LINE_DISABLE_CMD |=> !tearEnable_reg ##1 !tearSyncOutput)
		else $error("tear line not disabled");
	a_partial_single: assert property (@(posedge ref_clk) disable iff (rst)
		partial_reg && partialFirstRow == partialLastRow && scanRow == partialFirstRow
		|=> rowShown)
		else $error("one-row partial area hidden");
endmodule // pdcs_command_state

/* testbench/pdcs_host_model.sv */
// Purpose: Host processor model issuing command bytes and pixels
// Assumes: One byte or pixel per handshake on ref_clk
// Notes:   Released data buses show inverted data; hostAddr keeps the last address
`timescale 1ns/10ps
module pdcs_host_model import pdcs_pkg::*; (
	input  wire logic              ref_clk,
	input  wire logic              pixelReady,
	output logic                   hostWrite,
	output logic      [ADDR_W-1:0] hostAddr,
	output logic      [7:0]        hostData,
	output logic                   pixelValid,
	output logic      [PIX_W-1:0]  pixelData
);
	initial begin
		hostWrite = 1'b0;
		hostAddr = 16'h0000;
		hostData = 8'h00;
		pixelValid = 1'b0;
		pixelData = 24'h000000;
	end

	task automatic sendByte(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		hostWrite <= 1'b1;
		hostAddr <= a;
		hostData <= d;
		@(posedge ref_clk);
		hostWrite <= 1'b0;
		hostData <= ~d;
	endtask

	// Callers keep start and width even and set windows before writing
	task automatic setWindow(input logic [ADDR_W-1:0] b, input logic [9:0] s, input logic [9:0] e);
		sendByte(b, {6'h00, s[9:8]});
		sendByte(b + 16'h0001, s[7:0]);
		sendByte(b + 16'h0002, {6'h00, e[9:8]});
		sendByte(b + 16'h0003, e[7:0]);
	endtask

	task automatic sendPixel(input logic [PIX_W-1:0] d, output bit ok);
		ok = 1'b0;
		@(posedge ref_clk);
		pixelValid <= 1'b1;
		pixelData <= d;
		for (int n = 0; n < 16 && !ok; n++) begin
			@(posedge ref_clk);
			ok = pixelReady;
		end
		pixelValid <= 1'b0;
		pixelData <= ~d;
	endtask
endmodule // pdcs_host_model

/* testbench/pdcs_command_state_tb_top.sv */
// Purpose: Self-checking bench for the command state block
// Assumes: Host model drives the byte and pixel ports
// Notes:   Timing inputs are driven here as plain levels
`timescale 1ns/10ps
module pdcs_command_state_tb_top import pdcs_pkg::*; ;
	logic              ref_clk = 1'b0;
	logic              rst = 1'b1;
	logic              sleepMode = 1'b0;
	logic              verticalBlank = 1'b0;
	logic              horizontalBlank = 1'b0;
	logic              refreshFrame = 1'b0;
	logic [PIX_W-1:0]  framePixel = 24'h123456;
	logic [POS_W-1:0]  scanRow = 10'h000;
	logic              hostWrite, pixelValid, pixelReady, frameWrite, panelEnable, rowShown;
	logic              tearSyncOutput, imageOutputOn, forceBlack, forceWhite, partialMode;
	logic              tearEnable, tearBlankingSelect, tearRefreshSelect, columnReverse, bgrOrder;
	logic [ADDR_W-1:0] hostAddr;
	logic [7:0]        hostData;
	logic [PIX_W-1:0]  pixelData, frameData, panelPixel;
	logic [POS_W-1:0]  frameColumn, frameRow, partialFirstRow, partialLastRow;
	logic [8:0]        verticalFirstColumn, verticalLastColumn;
	int                fails = 0;
	int                compares = 0;
	bit                ok;

	always #50 ref_clk = ~ref_clk;

	pdcs_host_model i_pdcs_host_model (.ref_clk, .pixelReady, .hostWrite, .hostAddr,
		.hostData, .pixelValid, .pixelData);

	pdcs_command_state i_pdcs_command_state (.ref_clk, .rst, .hostWrite, .hostAddr,
		.hostData, .pixelValid, .pixelData, .sleepMode, .framePixel, .scanRow,
		.verticalBlank, .horizontalBlank, .refreshFrame, .pixelReady, .frameWrite,
		.frameColumn, .frameRow, .frameData, .panelPixel, .panelEnable, .rowShown,
		.tearSyncOutput, .imageOutputOn, .forceBlack, .forceWhite, .partialMode,
		.tearEnable, .tearBlankingSelect, .tearRefreshSelect, .columnReverse,
		.bgrOrder, .partialFirstRow, .partialLastRow, .verticalFirstColumn,
		.verticalLastColumn);

	task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic cmd(input logic [15:0] a, input logic [7:0] d);
		i_pdcs_host_model.sendByte(a, d);
		#1;
	endtask

	task automatic t_display();
		chk("lastRow", partialLastRow, 10'h1df);
		chk("lastVcol", verticalLastColumn, 9'h1df);
		cmd(IMAGE_OUTPUT_STOP_CMD, 8'h00);
		chk("outOn", imageOutputOn, 1'b0);
		cmd(IMAGE_OUTPUT_START_CMD, 8'h00);
		cmd(IMAGE_OUTPUT_START_CMD, 8'h00);
		chk("outOn", imageOutputOn, 1'b1);
		cmd(FORCE_ALL_BLACK_CMD, 8'h00);
		wt(1);
		chk("black", panelPixel, PIXEL_BLACK);
		cmd(FORCE_ALL_WHITE_CMD, 8'h00);
		chk("blackOff", forceBlack, 1'b0);
		wt(1);
		chk("white", panelPixel, PIXEL_WHITE);
		cmd(NORMAL_MODE_ON_CMD, 8'h00);
		wt(1);
		chk("whiteOff", forceWhite, 1'b0);
		chk("image", panelPixel, 24'h123456);
		chk("enable", panelEnable, 1'b1);
		cmd(SCAN_DIRECTION_CONTROL, 8'h08);
		wt(1);
		chk("bgr", panelPixel, 24'h563412);
		chk("bgrBit", bgrOrder, 1'b1);
		cmd(IMAGE_OUTPUT_STOP_CMD, 8'h00);
		wt(1);
		chk("outEnable", panelEnable, 1'b0);
		chk("outBlank", panelPixel, PIXEL_BLACK);
		$display("test display done");
	endtask

	task automatic t_write();
		logic [9:0] col[5] = '{10'd2, 10'd3, 10'd2, 10'd3, 10'd2};
		logic [9:0] row[5] = '{10'd4, 10'd4, 10'd5, 10'd5, 10'd4};
		i_pdcs_host_model.setWindow(COLUMN_START_HIGH, 10'd2, 10'd3);
		i_pdcs_host_model.setWindow(ROW_START_HIGH, 10'd4, 10'd5);
		cmd(FRAME_WRITE_BEGIN_CMD, 8'h00);
		for (int k = 0; k < 5; k++) begin
			if (k == 3)
				cmd(FRAME_WRITE_RESUME_CMD, 8'h00);
			i_pdcs_host_model.sendPixel(24'ha50000 + 24'(k), ok);
			#1;
			chk("accepted", ok, 1'b1);
			chk("strobe", frameWrite, 1'b1);
			chk("column", frameColumn, col[k]);
			chk("row", frameRow, row[k]);
			chk("data", frameData, 24'ha50000 + 24'(k));
		end
		cmd(SCAN_DIRECTION_CONTROL, 8'h40);
		chk("reverse", columnReverse, 1'b1);
		cmd(FRAME_WRITE_BEGIN_CMD, 8'h00);
		i_pdcs_host_model.sendPixel(24'h00ff00, ok);
		#1;
		chk("revColumn", frameColumn, 10'd3);
		i_pdcs_host_model.sendPixel(24'h0000ff, ok);
		#1;
		chk("revNext", frameColumn, 10'd2);
		$display("test write done");
	endtask

	task automatic t_tear();
		@(posedge ref_clk) horizontalBlank <= 1'b1;
		cmd(TEAR_OUTPUT_CONTROL, 8'h01);
		cmd(TEAR_OUTPUT_CONTROL, 8'h02);
		chk("tear_line_enable_cmd", tearEnable, 1'b1);
		chk("blankSel", tearBlankingSelect, 1'b1);
		chk("refSel", tearRefreshSelect, 1'b0);
		wt(1);
		chk("teHblank", tearSyncOutput, 1'b1);
		@(posedge ref_clk) sleepMode <= 1'b1;
		wt(2);
		chk("teSleep", tearSyncOutput, 1'b0);
		@(posedge ref_clk) sleepMode <= 1'b0;
		cmd(TEAR_LINE_DISABLE_CMD, 8'h00);
		chk("tear_line_disable_cmd", tearEnable, 1'b0);
		cmd(TEAR_OUTPUT_CONTROL, 8'h03);
		wt(1);
		chk("teNoRefresh", tearSyncOutput, 1'b0);
		@(posedge ref_clk) refreshFrame <= 1'b1;
		wt(2);
		chk("teRefresh", tearSyncOutput, 1'b1);
		cmd(TEAR_LINE_DISABLE_CMD, 8'h00);
		cmd(TEAR_OUTPUT_CONTROL, 8'h00);
		wt(1);
		chk("teVonly", tearSyncOutput, 1'b0);
		@(posedge ref_clk) verticalBlank <= 1'b1;
		wt(2);
		chk("teVblank", tearSyncOutput, 1'b1);
		$display("test tear done");
	endtask

	task automatic t_partial();
		cmd(PARTIAL_START_ROW_HIGH, 8'h01);
		cmd(PARTIAL_END_ROW_LOW, 8'h10);
		cmd(PARTIAL_END_ROW_HIGH, 8'h00);
		cmd(FORCE_ALL_BLACK_CMD, 8'h00);
		wt(1);
		chk("blackDispOff", panelEnable, 1'b1);
		cmd(PARTIAL_MODE_ON_CMD, 8'h00);
		chk("ptlMode", partialMode, 1'b1);
		chk("blackOff", forceBlack, 1'b0);
		chk("firstRow", partialFirstRow, 10'h100);
		chk("lastRowSet", partialLastRow, 10'h010);
		cmd(VERTICAL_PARTIAL_START_HIGH, 8'h03);
		chk("firstVcol", verticalFirstColumn, 9'h100);
		@(posedge ref_clk) scanRow <= 10'h005;
		wt(2);
		chk("shownWrap", rowShown, 1'b1);
		@(posedge ref_clk) scanRow <= 10'h050;
		wt(2);
		chk("hidden", rowShown, 1'b0);
		cmd(PARTIAL_END_ROW_HIGH, 8'h01);
		cmd(PARTIAL_END_ROW_LOW, 8'h00);
		@(posedge ref_clk) scanRow <= 10'h100;
		wt(2);
		chk("oneRow", rowShown, 1'b1);
		@(posedge ref_clk) scanRow <= 10'h101;
		wt(2);
		chk("belowRow", rowShown, 1'b0);
		$display("test partial done");
	endtask

	task automatic conclude();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		#1;
		t_display();
		t_write();
		t_tear();
		t_partial();
		conclude();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		fails++;
		conclude();
	end
endmodule // pdcs_command_state_tb_top
